// ==== core/dcbcl_pkg.sv ====
package dcbcl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS    = 50;
  localparam int TENTH_NS  = 100_000_000;
  localparam int TENTH_CYC = (TENTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP_NS   = 10_000_000;
  localparam int RAMP_CYC  = (RAMP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------
  // Input function codes and scales
  // ----------------------------------------
  localparam logic [7:0]  FN_BRAKE   = 8'h07;
  localparam logic [7:0]  FN_LIMIT   = 8'h27;
  localparam logic [15:0] FULL_SCALE = 16'h1770;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_FSEL_LO = 12'h000;
  localparam logic [11:0] OFS_FSEL_HI = 12'h004;
  localparam logic [11:0] OFS_CTRL    = 12'h008;
  localparam logic [11:0] OFS_AFREQ   = 12'h00C;
  localparam logic [11:0] OFS_BTIME   = 12'h010;
  localparam logic [11:0] OFS_BTORQ   = 12'h014;
  localparam logic [11:0] OFS_LIM1    = 12'h018;
  localparam logic [11:0] OFS_LIM2    = 12'h01C;
  localparam logic [11:0] OFS_STATUS  = 12'h020;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] rsv1;
    logic [2:0]  rsv0;
    logic [4:0]  pulse;
    logic [5:0]  rsv;
    logic        end_char;
    logic        auto_en;
  } dcbcl_ctrl_s;

  typedef struct packed {
    logic [5:0] rsv1;
    logic [9:0] dur;
    logic [5:0] rsv0;
    logic [9:0] wait_t;
  } dcbcl_btime_s;

  typedef struct packed {
    logic [5:0] rsv1;
    logic [9:0] st_time;
    logic       rsv0;
    logic [6:0] st_torque;
    logic       rsv;
    logic [6:0] torque;
  } dcbcl_btorq_s;

  typedef struct packed {
    logic [3:0]  rsv1;
    logic [11:0] tconst;
    logic [7:0]  trip;
    logic [5:0]  rsv0;
    logic [1:0]  lchar;
  } dcbcl_lim_s;

  localparam logic [15:0] AFREQ_RST = 16'h0032;
  localparam dcbcl_ctrl_s CTRL_RST = '{rsv1: 16'h0000, rsv0: 3'h0, pulse: 5'h0A,
                                       rsv: 6'h00, end_char: 1'b1, auto_en: 1'b0};
  localparam dcbcl_lim_s  LIM_RST  = '{rsv1: 4'h0, tconst: 12'h064, trip: 8'h0F,
                                       rsv0: 6'h00, lchar: 2'h1};

  typedef enum logic [1:0] {
    LC_OFF,
    LC_ACC_CONST,
    LC_CONST,
    LC_ALL
  } dcbcl_lchar_e;

endpackage : dcbcl_pkg

// ==== core/dcbcl_timer.sv ====
`timescale 1ns/1ps

// Down-counter in tenths of a second; load restarts the prescaler so the
// first tenth is always whole.
module dcbcl_timer #(
  parameter int TICK_CYC = dcbcl_pkg::TENTH_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic [9:0] value_i,
  output logic            done_o
);

  logic [23:0] pre_q;
  logic [9:0]  cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= 24'h000000;
      cnt_q <= 10'h000;
    end else if (load_i) begin
      pre_q <= 24'h000000;
      cnt_q <= value_i;
    end else if (cnt_q != 10'h000) begin
      if (pre_q == 24'(TICK_CYC - 1)) begin
        pre_q <= 24'h000000;
        cnt_q <= cnt_q - 10'h001;
      end else begin
        pre_q <= pre_q + 24'h000001;
      end
    end
  end

  assign done_o = (cnt_q == 10'h000);

endmodule : dcbcl_timer

// ==== core/dcbcl_core.sv ====
`timescale 1ns/1ps

module dcbcl_core #(
  parameter int TICK_CYC = dcbcl_pkg::TENTH_CYC,
  parameter int RAMP_CYC = dcbcl_pkg::RAMP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [7:0]  din_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [7:0]  motor_current_i,
  input  wire logic        accel_i,
  input  wire logic        const_i,
  input  wire logic        decel_i,
  input  wire logic        run_start_i,
  output logic             brake_active_o,
  output logic [6:0]       brake_torque_o,
  output logic [4:0]       brake_pulse_o,
  output logic             accel_hold_o,
  output logic             limit_active_o,
  output logic             limit_group_o,
  output logic [15:0]      freq_limit_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  typedef enum logic [1:0] {
    BR_IDLE,
    BR_START,
    BR_WAIT,
    BR_ON
  } dcbcl_brk_e;

  function automatic logic [7:0] fn_mask(input logic [7:0][7:0] sel, input logic [7:0] code);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (sel[i] == code);
    end
    return m;
  endfunction : fn_mask

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return (a == ofs);
  endfunction : hit

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0][7:0]        fsel_q;
  dcbcl_pkg::dcbcl_ctrl_s  ctrl_q;
  logic [15:0]            afreq_q;
  dcbcl_pkg::dcbcl_btime_s btime_q;
  dcbcl_pkg::dcbcl_btorq_s btorq_q;
  dcbcl_pkg::dcbcl_lim_s   lim1_q;
  dcbcl_pkg::dcbcl_lim_s   lim2_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic                   mapped;
  logic                   wr_en;
  logic [31:0]            rd_val;
  logic [31:0]            status;
  dcbcl_brk_e             st_q;
  logic                   lim_act_q;
  logic                   grp_q;

  assign wr_en = psel_i & penable_i & pwrite_i & pready_q & ~pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    if (hit(paddr_i, dcbcl_pkg::OFS_FSEL_LO)) begin
      rd_val = fsel_q[3:0];
    end else if (hit(paddr_i, dcbcl_pkg::OFS_FSEL_HI)) begin
      rd_val = fsel_q[7:4];
    end else if (hit(paddr_i, dcbcl_pkg::OFS_CTRL)) begin
      rd_val = ctrl_q;
    end else if (hit(paddr_i, dcbcl_pkg::OFS_AFREQ)) begin
      rd_val = {16'h0000, afreq_q};
    end else if (hit(paddr_i, dcbcl_pkg::OFS_BTIME)) begin
      rd_val = btime_q;
    end else if (hit(paddr_i, dcbcl_pkg::OFS_BTORQ)) begin
      rd_val = btorq_q;
    end else if (hit(paddr_i, dcbcl_pkg::OFS_LIM1)) begin
      rd_val = lim1_q;
    end else if (hit(paddr_i, dcbcl_pkg::OFS_LIM2)) begin
      rd_val = lim2_q;
    end else if (hit(paddr_i, dcbcl_pkg::OFS_STATUS)) begin
      rd_val = status;
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~mapped;
      prdata_q  <= (psel_i & penable_i & ~pready_q & ~pwrite_i) ? rd_val : 32'h00000000;
    end
  end

  // Reserved bits are forced to zero on write so they read back as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsel_q  <= '0;
      ctrl_q  <= dcbcl_pkg::CTRL_RST;
      afreq_q <= dcbcl_pkg::AFREQ_RST;
      btime_q <= '0;
      btorq_q <= '0;
      lim1_q  <= dcbcl_pkg::LIM_RST;
      lim2_q  <= dcbcl_pkg::LIM_RST;
    end else if (wr_en) begin
      if (hit(paddr_i, dcbcl_pkg::OFS_FSEL_LO)) begin
        fsel_q[3:0] <= pwdata_i;
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_FSEL_HI)) begin
        fsel_q[7:4] <= pwdata_i;
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_CTRL)) begin
        ctrl_q          <= '0;
        ctrl_q.auto_en  <= pwdata_i[0];
        ctrl_q.end_char <= pwdata_i[1];
        ctrl_q.pulse    <= pwdata_i[12:8];
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_AFREQ)) begin
        afreq_q <= pwdata_i[15:0];
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_BTIME)) begin
        btime_q        <= '0;
        btime_q.wait_t <= pwdata_i[9:0];
        btime_q.dur    <= pwdata_i[25:16];
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_BTORQ)) begin
        btorq_q           <= '0;
        btorq_q.torque    <= pwdata_i[6:0];
        btorq_q.st_torque <= pwdata_i[14:8];
        btorq_q.st_time   <= pwdata_i[25:16];
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_LIM1)) begin
        lim1_q        <= '0;
        lim1_q.lchar  <= pwdata_i[1:0];
        lim1_q.trip   <= pwdata_i[15:8];
        lim1_q.tconst <= pwdata_i[27:16];
      end
      if (hit(paddr_i, dcbcl_pkg::OFS_LIM2)) begin
        lim2_q        <= '0;
        lim2_q.lchar  <= pwdata_i[1:0];
        lim2_q.trip   <= pwdata_i[15:8];
        lim2_q.tconst <= pwdata_i[27:16];
      end
    end
  end

  assign status = {27'h0000000, grp_q, lim_act_q, 1'b0, st_q};

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  logic [7:0] din_m_q;
  logic [7:0] din_s_q;
  logic       req_lvl;
  logic       req_prev_q;
  logic       sel_lvl;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_m_q <= 8'h00;
      din_s_q <= 8'h00;
    end else begin
      din_m_q <= din_i;
      din_s_q <= din_m_q;
    end
  end

  // Inputs with any other function code are masked out here
  assign req_lvl = |(din_s_q & fn_mask(fsel_q, dcbcl_pkg::FN_BRAKE));
  assign sel_lvl = |(din_s_q & fn_mask(fsel_q, dcbcl_pkg::FN_LIMIT));

  // ----------------------------------------
  // DC braking sequencer
  // ----------------------------------------
  dcbcl_brk_e st_d;
  logic       src_q;
  logic       src_d;
  logic       auto_prev_q;
  logic       start_prev_q;
  logic       auto_lvl;
  logic       tm_load;
  logic [9:0] tm_val;
  logic       tm_done;

  assign auto_lvl = ctrl_q.auto_en & decel_i & (out_freq_i <= afreq_q);

  always_comb begin
    st_d    = st_q;
    src_d   = src_q;
    tm_load = 1'b0;
    tm_val  = btime_q.wait_t;
    case (st_q)
      BR_IDLE: begin
        if (req_lvl & ~req_prev_q) begin
          st_d    = BR_WAIT;
          src_d   = 1'b1;
          tm_load = 1'b1;
        end else if (auto_lvl & ~auto_prev_q) begin
          st_d    = BR_WAIT;
          src_d   = 1'b0;
          tm_load = 1'b1;
        end else if (run_start_i & ~start_prev_q & (btorq_q.st_time != 10'h000)) begin
          st_d    = BR_START;
          tm_load = 1'b1;
          tm_val  = btorq_q.st_time;
        end
      end
      BR_START: begin
        if (tm_done) begin
          st_d = BR_IDLE;
        end
      end
      BR_WAIT: begin
        if (src_q & ctrl_q.end_char & ~req_lvl) begin
          st_d = BR_IDLE;
        end else if (tm_done) begin
          st_d    = BR_ON;
          tm_load = 1'b1;
          tm_val  = btime_q.dur;
        end
      end
      BR_ON: begin
        if (src_q & ctrl_q.end_char) begin
          if (~req_lvl) begin
            st_d = BR_IDLE;
          end
        end else if (tm_done) begin
          st_d = BR_IDLE;
        end
      end
      default: begin
        st_d = BR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q         <= BR_IDLE;
      src_q        <= 1'b0;
      req_prev_q   <= 1'b0;
      auto_prev_q  <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      st_q         <= st_d;
      src_q        <= src_d;
      req_prev_q   <= req_lvl;
      auto_prev_q  <= auto_lvl;
      start_prev_q <= run_start_i;
    end
  end

  dcbcl_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tm_load),
    .value_i (tm_val),
    .done_o  (tm_done)
  );

  // Brake outputs follow the state, and brake_pulse_o follows the pulse field, one cycle later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brake_active_o <= 1'b0;
      brake_torque_o <= 7'h00;
      accel_hold_o   <= 1'b0;
      brake_pulse_o  <= dcbcl_pkg::CTRL_RST.pulse;
    end else begin
      brake_active_o <= (st_q == BR_ON) | (st_q == BR_START);
      brake_torque_o <= (st_q == BR_ON) ? btorq_q.torque :
                        (st_q == BR_START) ? btorq_q.st_torque : 7'h00;
      accel_hold_o   <= (st_q == BR_START);
      brake_pulse_o  <= ctrl_q.pulse;
    end
  end

  // ----------------------------------------
  // Current limiter
  // ----------------------------------------
  dcbcl_pkg::dcbcl_lim_s lim;
  logic                  lim_en;
  logic                  over;
  logic [17:0]           rpre_q;
  logic                  rtick;
  logic [15:0]           acc_q;
  logic [15:0]           acc_add;
  logic [15:0]           fcap_q;

  assign lim   = grp_q ? lim2_q : lim1_q;
  assign rtick = (rpre_q == 18'(RAMP_CYC - 1));

  always_comb begin
    case (dcbcl_pkg::dcbcl_lchar_e'(lim.lchar))
      dcbcl_pkg::LC_OFF:       lim_en = 1'b0;
      dcbcl_pkg::LC_ACC_CONST: lim_en = accel_i | const_i;
      dcbcl_pkg::LC_CONST:     lim_en = const_i;
      dcbcl_pkg::LC_ALL:       lim_en = accel_i | const_i | decel_i;
      default:                 lim_en = 1'b0;
    endcase
  end

  assign over    = lim_en & (motor_current_i >= lim.trip);
  assign acc_add = acc_q + (rtick ? dcbcl_pkg::FULL_SCALE : 16'h0000);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grp_q <= 1'b0;
    end else begin
      grp_q <= sel_lvl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rpre_q <= 18'h00000;
    end else if (~lim_act_q | rtick) begin
      rpre_q <= 18'h00000;
    end else begin
      rpre_q <= rpre_q + 18'h00001;
    end
  end

  // Full scale per time constant; one step of 0.01 Hz per cycle at most
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim_act_q <= 1'b0;
      acc_q     <= 16'h0000;
      fcap_q    <= 16'h0000;
    end else if (~lim_act_q) begin
      lim_act_q <= over;
      acc_q     <= 16'h0000;
      fcap_q    <= out_freq_i;
    end else if (~over) begin
      lim_act_q <= 1'b0;
      acc_q     <= 16'h0000;
    end else if ((acc_add >= {4'h0, lim.tconst}) && (fcap_q != 16'h0000)) begin
      acc_q  <= acc_add - {4'h0, lim.tconst};
      fcap_q <= fcap_q - 16'h0001;
    end else begin
      acc_q <= acc_add;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      limit_active_o <= 1'b0;
      limit_group_o  <= 1'b0;
      freq_limit_o   <= 16'h0000;
    end else begin
      limit_active_o <= lim_act_q;
      limit_group_o  <= grp_q;
      freq_limit_o   <= lim_act_q ? fcap_q : out_freq_i;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

endmodule : dcbcl_core

// ==== sim/dcbcl_core_checker.sv ====
`timescale 1ns/1ps

module dcbcl_core_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] out_freq_i,
  input wire logic        accel_i,
  input wire logic        const_i,
  input wire logic        decel_i,
  input wire logic        brake_active_o,
  input wire logic [6:0]  brake_torque_o,
  input wire logic        accel_hold_o,
  input wire logic        limit_active_o,
  input wire logic [15:0] freq_limit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  property p_ready_answer;
    psel_i && !penable_i |-> ##[2:3] pready_o;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no answer after setup");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_with_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_rdata_idle;
    !pready_o |-> prdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

  // ----------------------------------------
  // Braking and limiting
  // ----------------------------------------
  property p_torque_idle;
    !brake_active_o |-> brake_torque_o == 7'h00;
  endproperty
  a_torque_idle: assert property (p_torque_idle) else $error("torque while not braking");
  property p_hold_brake;
    accel_hold_o |-> brake_active_o;
  endproperty
  a_hold_brake: assert property (p_hold_brake) else $error("hold without braking");
  property p_limit_state;
    limit_active_o |-> $past(accel_i || const_i || decel_i, 2);
  endproperty
  a_limit_state: assert property (p_limit_state) else $error("limiting with no drive state");
  property p_ramp_down;
    limit_active_o && $past(limit_active_o) |-> freq_limit_o <= $past(freq_limit_o);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("ceiling rose while limiting");
  property p_follow;
    !limit_active_o && $past(!limit_active_o) && $past(rst_n_i) |-> freq_limit_o == $past(out_freq_i);
  endproperty
  a_follow: assert property (p_follow) else $error("ceiling not following frequency");
endmodule : dcbcl_core_checker

bind dcbcl_core dcbcl_core_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .out_freq_i(out_freq_i), .accel_i(accel_i), .const_i(const_i), .decel_i(decel_i),
  .brake_active_o(brake_active_o), .brake_torque_o(brake_torque_o), .accel_hold_o(accel_hold_o),
  .limit_active_o(limit_active_o), .freq_limit_o(freq_limit_o));

// ==== sim/dcbcl_ctrl_model.sv ====
`timescale 1ns/1ps

// Outside controller: levels change only just after a clock edge
module dcbcl_ctrl_model (
  input  wire logic       clk_i,
  output logic [7:0]      din_o
);
  initial din_o = 8'h00;

  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clk_i);
    din_o[idx] <= lvl;
  endtask : set_pin
endmodule : dcbcl_ctrl_model

// ==== sim/dcbcl_core_bench.sv ====
`timescale 1ns/1ps

module dcbcl_core_bench;
  localparam int T = 10;
  localparam logic [3:0][2:0] LMASK = {3'b111, 3'b010, 3'b011, 3'b000};
  logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic        accel, cnst, decel, run_start, brake_active, accel_hold, limit_active, limit_group;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  din, current;
  logic [15:0] out_freq, freq_limit;
  logic [6:0]  brake_torque;
  logic [4:0]  brake_pulse;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          err_count, n_checks, n, k, tq;

  dcbcl_ctrl_model ctl (.clk_i(clk_i), .din_o(din));

  dcbcl_core #(.TICK_CYC(T), .RAMP_CYC(4)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .din_i(din), .out_freq_i(out_freq), .motor_current_i(current), .accel_i(accel), .const_i(cnst),
    .decel_i(decel), .run_start_i(run_start), .brake_active_o(brake_active),
    .brake_torque_o(brake_torque), .brake_pulse_o(brake_pulse), .accel_hold_o(accel_hold),
    .limit_active_o(limit_active), .limit_group_o(limit_group), .freq_limit_o(freq_limit));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic check_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_rng

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Bus master and helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
    exp_q.push_back(x);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b1, a, d, {1'b0, er, 32'h0000_0000});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic er = 1'b0);
    apb(1'b0, a, 32'h0000_0000, {1'b1, er, x});
  endtask : rd

  task automatic fsel(input int p, input logic [7:0] c);
    wr(p < 4 ? dcbcl_pkg::OFS_FSEL_LO : dcbcl_pkg::OFS_FSEL_HI, 32'(c) << (8 * (p % 4)));
  endtask : fsel

  function automatic logic sig(input int s);
    return s == 0 ? brake_active : s == 1 ? accel_hold : limit_active;
  endfunction : sig

  // Samples on the falling edge so registered outputs have settled
  task automatic wait_sig(input int s, input logic lvl, input int maxc, output int cnt);
    cnt = 0;
    @(negedge clk_i);
    while (sig(s) !== lvl && cnt < maxc) begin
      @(negedge clk_i);
      cnt++;
    end
    @(posedge clk_i);
  endtask : wait_sig

  always @(posedge clk_i) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33])
        check(prdata, e[31:0]);
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {out_freq, current, accel, cnst, decel, run_start} = '0;
    void'($urandom(34715));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check({27'h0, brake_pulse}, 32'h0000_000A);
    rd(dcbcl_pkg::OFS_CTRL, 32'h0000_0A02);
    rd(dcbcl_pkg::OFS_AFREQ, 32'h0000_0032);
    rd(dcbcl_pkg::OFS_BTIME, 32'h0000_0000);
    rd(dcbcl_pkg::OFS_BTORQ, 32'h0000_0000);
    rd(dcbcl_pkg::OFS_LIM2, 32'h0064_0F01);
    rd(12'h024, 32'h0000_0000, 1'b1);
    wr(12'h024, 32'hFFFF_FFFF, 1'b1);
    wr(dcbcl_pkg::OFS_CTRL, 32'h0000_1E02);
    repeat (2) @(posedge clk_i);
    check({27'h0, brake_pulse}, 32'h0000_001E);
    $display("registers done");
    k  = $urandom_range(7);
    tq = $urandom_range(100);
    fsel(k, 8'h07);
    wr(dcbcl_pkg::OFS_BTIME, 32'h0003_0002);
    wr(dcbcl_pkg::OFS_BTORQ, 32'(tq));
    ctl.set_pin(k ^ 4, 1'b1);
    wait_sig(0, 1'b1, 40, n);
    check_rng(n, 40, 40);
    ctl.set_pin(k ^ 4, 1'b0);
    for (int ec = 1; ec >= 0; ec--) begin
      wr(dcbcl_pkg::OFS_CTRL, 32'h0000_0A00 | 32'(ec << 1));
      ctl.set_pin(k, 1'b1);
      wait_sig(0, 1'b1, 3 * T, n);
      check_rng(n, 2 * T, 2 * T + 8);
      check({25'h0, brake_torque}, 32'(tq));
      wait_sig(0, 1'b0, 5 * T, n);
      if (ec == 1) begin
        check_rng(n, 5 * T, 5 * T);
        ctl.set_pin(k, 1'b0);
        wait_sig(0, 1'b0, 10, n);
        check_rng(n, 0, 9);
      end else begin
        check_rng(n, 3 * T - 3, 3 * T + 3);
        ctl.set_pin(k, 1'b0);
      end
      repeat (5) @(posedge clk_i);
    end
    $display("input braking done");
    decel    <= 1'b1;
    out_freq <= 16'h0064;
    for (int en = 0; en < 2; en++) begin
      wr(dcbcl_pkg::OFS_CTRL, 32'h0000_0A02 | 32'(en));
      out_freq <= 16'h0032;
      wait_sig(0, 1'b1, 3 * T, n);
      check_rng(n, en ? 2 * T : 3 * T, en ? 2 * T + 8 : 3 * T);
      wait_sig(0, 1'b0, 4 * T, n);
      if (en == 1)
        check_rng(n, 3 * T - 3, 3 * T + 3);
      out_freq <= 16'h0064;
      repeat (3) @(posedge clk_i);
    end
    decel <= 1'b0;
    $display("auto braking done");
    tq = $urandom_range(100);
    wr(dcbcl_pkg::OFS_BTORQ, 32'h0002_0000 | 32'(tq << 8));
    run_start <= 1'b1;
    wait_sig(1, 1'b1, 10, n);
    check_rng(n, 0, 9);
    check({25'h0, brake_torque}, 32'(tq));
    wait_sig(1, 1'b0, 3 * T, n);
    check_rng(n, 2 * T - 3, 2 * T + 3);
    run_start <= 1'b0;
    $display("start braking done");
    out_freq <= 16'h0BB8;
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < 3; s++) begin
        wr(dcbcl_pkg::OFS_LIM1, 32'h0001_0F00 | 32'(c));
        {decel, cnst, accel} <= 3'(1 << s);
        current <= 8'h0F;
        wait_sig(2, 1'b1, 8, n);
        check({31'h0, n < 8}, {31'h0, LMASK[c][s]});
        current <= 8'($urandom_range(14));
        wait_sig(2, 1'b0, 8, n);
        {decel, cnst, accel} <= 3'b000;
      end
    wr(dcbcl_pkg::OFS_LIM1, 32'h0001_0F03);
    cnst    <= 1'b1;
    current <= 8'h14;
    repeat (200) @(posedge clk_i);
    check({31'h0, freq_limit < 16'h0BB8}, 32'h1);
    k = $urandom_range(7);
    fsel(k, 8'h27);
    wr(dcbcl_pkg::OFS_LIM2, 32'h0001_1E03);
    check({31'h0, limit_group}, 32'h0);
    ctl.set_pin(k, 1'b1);
    wait_sig(2, 1'b0, 10, n);
    check_rng(n, 0, 9);
    check({31'h0, limit_group}, 32'h1);
    rd(dcbcl_pkg::OFS_STATUS, 32'h0000_0010);
    ctl.set_pin(k, 1'b0);
    wait_sig(2, 1'b1, 10, n);
    check_rng(n, 0, 9);
    current <= 8'h00;
    repeat (5) @(posedge clk_i);
    cnst <= 1'b0;
    $display("limiting done");
    report_and_stop();
  end
endmodule : dcbcl_core_bench
